// File: bench/cbc_bus_partner.sv
module cbc_bus_partner (
  // Clock and reset
  input  wire logic                  i_clock,
  input  wire logic                  i_reset,
  // Cycle request from the block
  input  wire logic                  i_cycle_start,
  input  wire logic                  i_cycle_req,
  input  wire cbc_pkg::cbc_cycle_t   i_cycle_kind,
  // Answer pace and vector
  input  wire logic [3:0]            i_delay,
  input  wire logic [7:0]            i_vector,
  // Answer
  output logic                       o_cycle_done,
  output logic [cbc_pkg::DATA_W-1:0] o_bus_data
);
  import cbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] wait_cnt_r;

  // One done per request; a new start restarts the count
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_cycle_req || i_cycle_start || o_cycle_done) begin
      wait_cnt_r   <= 4'h0;
      o_cycle_done <= 1'b0;
    end else if (wait_cnt_r == i_delay) begin
      o_cycle_done <= 1'b1;
    end else begin
      wait_cnt_r <= wait_cnt_r + 4'h1;
    end
  end

  // Outside the second acknowledge the bus inverts every cycle; its low byte alternates 5a and a5, so stale data can match vector a5
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_bus_data <= 64'h5a5a_5a5a_5a5a_5a5a;
    end else if (i_cycle_req && i_cycle_kind == CYC_INTA2) begin
      o_bus_data <= {56'h0, i_vector};
    end else begin
      o_bus_data <= ~o_bus_data;
    end
  end
endmodule

// File: bench/test_cbc_ctrl_pins.sv
module test_cbc_ctrl_pins;
  import cbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic i_clock, i_reset, i_flush_n, i_hold, i_fpu_fault_override_n, i_warm_init;
  logic i_maskable_irq_input, i_inquire_valid, i_cycle_done, i_core_bus_busy, i_irq_enable;
  logic i_fill_we, i_fpu_unmasked_exc, i_fpu_check, i_fpu_clear, i_ctl_write, i_ctl_cd;
  logic i_ctl_nw, o_inq_hit_n_r, o_snoop_line_dirty_n_r, o_bus_surrender_ack_r;
  logic o_bus_drive_en_r, o_test_float_r, o_cycle_start_r, o_cycle_req_r, o_vector_take_r;
  logic o_pipe_flush_r, o_fpu_fault_output_n_r, o_fpu_exc_ignored_r, o_fpu_exc_trap_r;
  logic o_cache_disable_bit_r, o_no_writethrough_bit_r;
  cbc_idx_t          i_inquire_index, i_fill_index, o_cycle_index_r;
  cbc_line_t         i_fill_state;
  cbc_cycle_t        o_cycle_kind_r;
  logic [DATA_W-1:0] i_bus_data;
  logic [VEC_W-1:0]  o_handler_vector_r, vector;
  logic [ADDR_W-1:0] o_fetch_addr_r;
  logic [3:0]        delay;
  int                n_errors = 0;
  int                samples_checked = 0;

  cbc_ctrl_pins dut_u (
    .i_clock, .i_reset, .i_flush_n, .i_hold, .i_fpu_fault_override_n, .i_warm_init,
    .i_maskable_irq_input, .i_inquire_valid, .i_inquire_index, .i_cycle_done, .i_bus_data,
    .i_core_bus_busy, .i_irq_enable, .i_fill_we, .i_fill_index, .i_fill_state,
    .i_fpu_unmasked_exc, .i_fpu_check, .i_fpu_clear, .i_ctl_write, .i_ctl_cd, .i_ctl_nw,
    .o_inq_hit_n_r, .o_snoop_line_dirty_n_r, .o_bus_surrender_ack_r, .o_bus_drive_en_r,
    .o_test_float_r, .o_cycle_start_r, .o_cycle_req_r, .o_cycle_kind_r, .o_cycle_index_r,
    .o_vector_take_r, .o_handler_vector_r, .o_pipe_flush_r, .o_fetch_addr_r,
    .o_fpu_fault_output_n_r, .o_fpu_exc_ignored_r, .o_fpu_exc_trap_r,
    .o_cache_disable_bit_r, .o_no_writethrough_bit_r);

  cbc_bus_partner partner_u (.i_clock, .i_reset, .i_cycle_start(o_cycle_start_r),
    .i_cycle_req(o_cycle_req_r), .i_cycle_kind(o_cycle_kind_r), .i_delay(delay),
    .i_vector(vector), .o_cycle_done(i_cycle_done), .o_bus_data(i_bus_data));

  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  task automatic at(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait, so a missing cycle fails instead of hanging
  task automatic wait_start(input cbc_cycle_t kind, input int idx);
    int n;
    n = 0;
    do begin
      at(1);
      #1;
      n++;
    end while (o_cycle_start_r !== 1'b1 && n < 300);
    check("cycle start", o_cycle_start_r, 1'b1);
    check("cycle kind", o_cycle_kind_r, kind);
    if (idx >= 0) check("cycle index", o_cycle_index_r, idx);
  endtask

  task automatic fill(input cbc_idx_t idx, input cbc_line_t st);
    at(1);
    i_fill_we <= 1'b1;
    i_fill_index <= idx;
    i_fill_state <= st;
    at(1);
    i_fill_we <= 1'b0;
  endtask

  task automatic inquire(input cbc_idx_t idx, input logic hit, input logic dirty);
    at(1);
    i_inquire_valid <= 1'b1;
    i_inquire_index <= idx;
    at(1);
    i_inquire_valid <= 1'b0;
    at(1);
    #1 check("inquire hit", o_inq_hit_n_r, !hit);
    check("inquire dirty", o_snoop_line_dirty_n_r, !dirty);
    at(1);
    #1 check("hit pulse end", o_inq_hit_n_r, 1'b1);
  endtask

  task automatic reset_check(input logic fl);
    at(1);
    i_reset <= 1'b1;
    i_flush_n <= fl;
    at(2);
    i_reset <= 1'b0;
    at(1);
    i_flush_n <= 1'b1;
    #1 check("test float", o_test_float_r, !fl);
    check("drive enable", o_bus_drive_en_r, 1'b1);
    check("surrender ack", o_bus_surrender_ack_r, 1'b0);
    check("fetch address", o_fetch_addr_r, RESET_VECTOR);
    check("cache disable", o_cache_disable_bit_r, CD_RST);
    check("no writethrough", o_no_writethrough_bit_r, NW_RST);
    check("fault output", o_fpu_fault_output_n_r, 1'b1);
    at(1);
    #1 check("strap float", o_bus_drive_en_r, fl);
  endtask

  task automatic run_inquire();
    fill(6'h05, 3'h4);
    fill(6'h07, 3'h1);
    fill(6'h09, 3'h3);
    inquire(6'h05, 1'b1, 1'b0);
    inquire(6'h07, 1'b1, 1'b0);
    inquire(6'h14, 1'b0, 1'b0);
  endtask

  // Dirty hit while surrendered: writeback must wait for the bus
  task automatic run_surrender();
    delay <= 4'h3;
    at(1);
    i_core_bus_busy <= 1'b1;
    i_hold <= 1'b1;
    at(4);
    #1 check("ack while busy", o_bus_surrender_ack_r, 1'b0);
    check("drive while busy", o_bus_drive_en_r, 1'b1);
    at(1);
    i_core_bus_busy <= 1'b0;
    at(1);
    #1 check("float first", o_bus_drive_en_r, 1'b0);
    check("ack after float", o_bus_surrender_ack_r, 1'b0);
    at(1);
    #1 check("ack raised", o_bus_surrender_ack_r, 1'b1);
    inquire(6'h09, 1'b1, 1'b1);
    repeat (3) begin
      at(1);
      #1 check("ack held", o_bus_surrender_ack_r, 1'b1);
      check("bus floated", o_bus_drive_en_r, 1'b0);
      check("no cycle in hold", o_cycle_req_r, 1'b0);
    end
    at(1);
    i_hold <= 1'b0;
    at(1);
    #1 check("ack dropped", o_bus_surrender_ack_r, 1'b0);
    check("drive resumed", o_bus_drive_en_r, 1'b1);
    wait_start(CYC_WRITEBACK, 9);
    at(10);
    #1 check("dirty cleared", o_snoop_line_dirty_n_r, 1'b1);
    inquire(6'h09, 1'b1, 1'b0);
  endtask

  task automatic run_irq();
    int n;
    delay <= 4'h2;
    vector <= 8'ha5;
    at(1);
    i_irq_enable <= 1'b0;
    i_maskable_irq_input <= 1'b1;
    at(4);
    #1 check("masked irq", o_cycle_req_r, 1'b0);
    at(1);
    i_irq_enable <= 1'b1;
    wait_start(CYC_INTA1, -1);
    at(1);
    i_maskable_irq_input <= 1'b0;
    wait_start(CYC_INTA2, -1);
    n = 0;
    do begin
      at(1);
      #1;
      n++;
    end while (o_vector_take_r !== 1'b1 && n < 50);
    check("vector take", o_vector_take_r, 1'b1);
    check("vector", o_handler_vector_r, 8'ha5);
  endtask

  task automatic run_flush();
    delay <= 4'h0;
    fill(6'h0c, 3'h3);
    at(1);
    i_flush_n <= 1'b0;
    at(1);
    i_flush_n <= 1'b1;
    wait_start(CYC_WRITEBACK, 12);
    wait_start(CYC_FLUSH_ACK, -1);
    at(4);
    inquire(6'h05, 1'b0, 1'b0);
    inquire(6'h0c, 1'b0, 1'b0);
  endtask

  task automatic run_warm_fpu();
    at(1);
    i_ctl_write <= 1'b1;
    i_ctl_cd <= 1'b0;
    i_ctl_nw <= 1'b0;
    at(1);
    i_ctl_write <= 1'b0;
    fill(6'h14, 3'h2);
    at(1);
    i_fpu_unmasked_exc <= 1'b1;
    at(1);
    i_fpu_unmasked_exc <= 1'b0;
    #1 check("fault raised", o_fpu_fault_output_n_r, 1'b0);
    at(1);
    i_warm_init <= 1'b1;
    at(1);
    #1 check("pipe flush", o_pipe_flush_r, 1'b1);
    check("fetch address", o_fetch_addr_r, RESET_VECTOR);
    at(1);
    i_warm_init <= 1'b0;
    #1 check("pipe flush end", o_pipe_flush_r, 1'b0);
    check("cd kept", o_cache_disable_bit_r, 1'b0);
    check("nw kept", o_no_writethrough_bit_r, 1'b0);
    check("fault kept", o_fpu_fault_output_n_r, 1'b0);
    inquire(6'h14, 1'b1, 1'b0);
    at(1);
    i_fpu_check <= 1'b1;
    i_fpu_fault_override_n <= 1'b0;
    at(1);
    i_fpu_check <= 1'b0;
    #1 check("ignored", {o_fpu_exc_ignored_r, o_fpu_exc_trap_r}, 2'b10);
    at(1);
    i_fpu_unmasked_exc <= 1'b1;
    i_fpu_fault_override_n <= 1'b1;
    at(1);
    i_fpu_unmasked_exc <= 1'b0;
    i_fpu_check <= 1'b1;
    at(1);
    i_fpu_check <= 1'b0;
    #1 check("trapped", {o_fpu_exc_ignored_r, o_fpu_exc_trap_r}, 2'b01);
    at(1);
    i_fpu_clear <= 1'b1;
    at(1);
    i_fpu_clear <= 1'b0;
    #1 check("fault cleared", o_fpu_fault_output_n_r, 1'b1);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    at(5000);
    n_errors++;
    complete_run();
  end

  initial begin
    i_reset = 1'b1;
    {i_flush_n, i_fpu_fault_override_n} = 2'b11;
    {i_hold, i_warm_init, i_maskable_irq_input, i_inquire_valid, i_core_bus_busy} = '0;
    {i_irq_enable, i_fill_we, i_fpu_unmasked_exc, i_fpu_check, i_fpu_clear} = '0;
    {i_ctl_write, i_ctl_cd, i_ctl_nw, i_inquire_index, i_fill_index, i_fill_state} = '0;
    delay = 4'h0;
    vector = 8'h00;
    at(2);
    i_reset <= 1'b0;
    reset_check(1'b0);
    reset_check(1'b1);
    run_inquire();
    run_surrender();
    run_irq();
    run_flush();
    run_warm_fpu();
    complete_run();
  end
endmodule

// File: logic/cbc_ctrl_pins.sv
module cbc_ctrl_pins
  import cbc_pkg::*;
(
  // Clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_reset,
  // Chipset control inputs
  input  wire logic                      i_flush_n,
  input  wire logic                      i_hold,
  input  wire logic                      i_fpu_fault_override_n,
  input  wire logic                      i_warm_init,
  input  wire logic                      i_maskable_irq_input,
  // Inquire port
  input  wire logic                      i_inquire_valid,
  input  wire cbc_pkg::cbc_idx_t          i_inquire_index,
  // Bus cycle completion and returned data
  input  wire logic                      i_cycle_done,
  input  wire logic [cbc_pkg::DATA_W-1:0] i_bus_data,
  // Core side
  input  wire logic                      i_core_bus_busy,
  input  wire logic                      i_irq_enable,
  input  wire logic                      i_fill_we,
  input  wire cbc_pkg::cbc_idx_t          i_fill_index,
  input  wire cbc_pkg::cbc_line_t         i_fill_state,
  input  wire logic                      i_fpu_unmasked_exc,
  input  wire logic                      i_fpu_check,
  input  wire logic                      i_fpu_clear,
  input  wire logic                      i_ctl_write,
  input  wire logic                      i_ctl_cd,
  input  wire logic                      i_ctl_nw,
  // Inquire results
  output logic                           o_inq_hit_n_r,
  output logic                           o_snoop_line_dirty_n_r,
  // Surrender and bus drive
  output logic                           o_bus_surrender_ack_r,
  output logic                           o_bus_drive_en_r,
  output logic                           o_test_float_r,
  // Bus cycle request
  output logic                           o_cycle_start_r,
  output logic                           o_cycle_req_r,
  output cbc_pkg::cbc_cycle_t             o_cycle_kind_r,
  output cbc_pkg::cbc_idx_t               o_cycle_index_r,
  // Interrupt vector
  output logic                           o_vector_take_r,
  output logic [cbc_pkg::VEC_W-1:0]       o_handler_vector_r,
  // Warm init
  output logic                           o_pipe_flush_r,
  output logic [cbc_pkg::ADDR_W-1:0]      o_fetch_addr_r,
  // FPU
  output logic                           o_fpu_fault_output_n_r,
  output logic                           o_fpu_exc_ignored_r,
  output logic                           o_fpu_exc_trap_r,
  // Control bits
  output logic                           o_cache_disable_bit_r,
  output logic                           o_no_writethrough_bit_r
);

  cbc_state_t state_r;
  cbc_state_t state_nxt;
  cbc_cycle_t kind_nxt;
  logic       start_nxt;
  logic       inval_we;
  logic       clean_we;
  logic       step_idx;
  cbc_idx_t   flush_idx_r;
  cbc_idx_t   wb_idx_r;
  cbc_line_t  wb_line_r;
  logic       wb_pending_r;
  logic       snoop_pend_r;
  logic       snoop_take;
  logic       flush_req_r;
  logic       rst_d_r;
  logic       warm_d_r;
  logic       fpu_pend_r;
  logic       mem_we;
  cbc_idx_t   mem_waddr;
  cbc_line_t  mem_wdata;
  cbc_idx_t   mem_raddr;
  cbc_line_t  mem_rdata;

  // Inquiries are taken only when no flush walk owns the read port
  assign snoop_take = i_inquire_valid && !snoop_pend_r && !wb_pending_r &&
                      (state_r == ST_IDLE || state_r == ST_FLOAT || state_r == ST_HOLD);
  assign mem_raddr  = (state_r == ST_FL_RD) ? flush_idx_r : i_inquire_index;

  // Sequencer writes win; a fill in the same cycle is dropped
  always_comb begin
    mem_we    = 1'b1;
    mem_waddr = flush_idx_r;
    mem_wdata = {1'b0, DST_INV};
    if (inval_we) begin
      mem_waddr = flush_idx_r;
    end else if (clean_we) begin
      mem_waddr = wb_idx_r;
      mem_wdata = {wb_line_r[LINE_IVALID], DST_EXCL};
    end else begin
      mem_we    = i_fill_we;
      mem_waddr = i_fill_index;
      mem_wdata = i_fill_state;
    end
  end

  cbc_line_mem u_line_mem (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (mem_wdata),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  always_comb begin
    state_nxt = state_r;
    kind_nxt  = o_cycle_kind_r;
    start_nxt = 1'b0;
    inval_we  = 1'b0;
    clean_we  = 1'b0;
    step_idx  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (i_hold && !i_core_bus_busy) begin
          state_nxt = ST_FLOAT;
        end else if (wb_pending_r) begin
          state_nxt = ST_WB;
          start_nxt = 1'b1;
          kind_nxt  = CYC_WRITEBACK;
        end else if (flush_req_r) begin
          state_nxt = ST_FL_RD;
        end else if (i_maskable_irq_input && i_irq_enable) begin
          state_nxt = ST_INTA1;
          start_nxt = 1'b1;
          kind_nxt  = CYC_INTA1;
        end
      end
      ST_FLOAT: state_nxt = ST_HOLD;
      ST_HOLD: begin
        if (!i_hold) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_FL_RD: state_nxt = ST_FL_CHK;
      ST_FL_CHK: begin
        if (line_dirty(mem_rdata)) begin
          state_nxt = ST_FL_WB;
          start_nxt = 1'b1;
          kind_nxt  = CYC_WRITEBACK;
        end else begin
          inval_we  = 1'b1;
          step_idx  = 1'b1;
        end
      end
      ST_FL_WB: begin
        if (i_cycle_done) begin
          inval_we  = 1'b1;
          step_idx  = 1'b1;
        end
      end
      ST_FL_ACK: begin
        if (i_cycle_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WB: begin
        if (i_cycle_done) begin
          clean_we  = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_INTA1: begin
        if (i_cycle_done) begin
          state_nxt = ST_INTA2;
          start_nxt = 1'b1;
          kind_nxt  = CYC_INTA2;
        end
      end
      ST_INTA2: begin
        if (i_cycle_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (step_idx) begin
      if (flush_idx_r == LAST_IDX) begin
        state_nxt = ST_FL_ACK;
        start_nxt = 1'b1;
        kind_nxt  = CYC_FLUSH_ACK;
      end else begin
        state_nxt = ST_FL_RD;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r     <= ST_IDLE;
      flush_idx_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (step_idx) begin
        flush_idx_r <= (flush_idx_r == LAST_IDX) ? '0 : flush_idx_r + cbc_idx_t'(1);
      end
    end
  end

  // Flush request: set wins over the clear taken when the walk starts
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rst_d_r        <= 1'b1;
      flush_req_r    <= 1'b0;
      o_test_float_r <= 1'b0;
    end else begin
      rst_d_r <= 1'b0;
      if (rst_d_r) begin
        o_test_float_r <= !i_flush_n;
      end else if (!i_flush_n) begin
        flush_req_r <= 1'b1;
      end else if (state_r == ST_IDLE && state_nxt == ST_FL_RD) begin
        flush_req_r <= 1'b0;
      end
    end
  end

  // Surrender handshake: float one cycle before acknowledging
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_bus_surrender_ack_r <= 1'b0;
      o_bus_drive_en_r      <= 1'b1;
    end else begin
      o_bus_surrender_ack_r <= (state_nxt == ST_HOLD);
      o_bus_drive_en_r      <= !(state_nxt == ST_FLOAT || state_nxt == ST_HOLD) &&
                               !o_test_float_r;
    end
  end

  AST_FLOAT_BEFORE_ACK: assert property (@(posedge i_clock) disable iff (i_reset)
    $rose(o_bus_surrender_ack_r) |-> !$past(o_bus_drive_en_r) && !o_bus_drive_en_r)
    else $error("acknowledge rose before the bus was floated");

  AST_FLOAT_DURING_ACK: assert property (@(posedge i_clock) disable iff (i_reset)
    o_bus_surrender_ack_r |-> !o_bus_drive_en_r)
    else $error("bus driven while surrender acknowledged");

  AST_ACK_RELEASE: assert property (@(posedge i_clock) disable iff (i_reset)
    o_bus_surrender_ack_r && !i_hold |=> !o_bus_surrender_ack_r &&
                                         (o_bus_drive_en_r || o_test_float_r))
    else $error("acknowledge not released after request dropped");

  AST_ACK_KEPT: assert property (@(posedge i_clock) disable iff (i_reset)
    o_bus_surrender_ack_r && i_hold |=> o_bus_surrender_ack_r)
    else $error("acknowledge dropped while request still asserted");

  // Inquiry lookup and writeback scheduling
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      snoop_pend_r           <= 1'b0;
      wb_pending_r           <= 1'b0;
      wb_idx_r               <= '0;
      wb_line_r              <= LINE_RST;
      o_inq_hit_n_r          <= 1'b1;
      o_snoop_line_dirty_n_r <= 1'b1;
    end else begin
      snoop_pend_r  <= snoop_take;
      o_inq_hit_n_r <= !(snoop_pend_r && line_hit(mem_rdata));
      if (snoop_take) begin
        wb_idx_r <= i_inquire_index;
      end
      if (snoop_pend_r && line_dirty(mem_rdata)) begin
        o_snoop_line_dirty_n_r <= 1'b0;
        wb_pending_r           <= 1'b1;
        wb_line_r              <= mem_rdata;
      end else if (clean_we) begin
        o_snoop_line_dirty_n_r <= 1'b1;
        wb_pending_r           <= 1'b0;
      end
    end
  end

  AST_HIT_REPORT: assert property (@(posedge i_clock) disable iff (i_reset)
    snoop_take ##1 line_hit(mem_rdata) |=> !o_inq_hit_n_r)
    else $error("inquire hit not reported two cycles after lookup");

  AST_DIRTY_NEEDS_WB: assert property (@(posedge i_clock) disable iff (i_reset)
    o_cycle_start_r && state_r == ST_WB |-> o_cycle_kind_r == CYC_WRITEBACK &&
                                           o_cycle_index_r == wb_idx_r &&
                                           !o_snoop_line_dirty_n_r)
    else $error("writeback cycle not aimed at the dirty inquired line");

  // Bus cycle request towards the bus unit
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_cycle_start_r <= 1'b0;
      o_cycle_req_r   <= 1'b0;
      o_cycle_kind_r  <= CYC_NONE;
      o_cycle_index_r <= '0;
    end else begin
      o_cycle_start_r <= start_nxt;
      if (start_nxt) begin
        o_cycle_req_r   <= 1'b1;
        o_cycle_kind_r  <= kind_nxt;
        o_cycle_index_r <= (state_r == ST_IDLE) ? wb_idx_r : flush_idx_r;
      end else if (i_cycle_done) begin
        o_cycle_req_r  <= 1'b0;
        o_cycle_kind_r <= CYC_NONE;
      end
    end
  end

  AST_FLUSH_ACK_LAST: assert property (@(posedge i_clock) disable iff (i_reset)
    o_cycle_start_r && o_cycle_kind_r == CYC_FLUSH_ACK |-> $past(flush_idx_r) == LAST_IDX)
    else $error("flush acknowledge issued before the last line");

  // Interrupt vector capture on the second acknowledge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_vector_take_r    <= 1'b0;
      o_handler_vector_r <= '0;
    end else begin
      o_vector_take_r <= (state_r == ST_INTA2) && i_cycle_done;
      if (state_r == ST_INTA2 && i_cycle_done) begin
        o_handler_vector_r <= i_bus_data[VEC_W-1:0];
      end
    end
  end

  AST_INTA_PAIR: assert property (@(posedge i_clock) disable iff (i_reset)
    o_vector_take_r |-> $past(o_cycle_kind_r) == CYC_INTA2 && o_cycle_kind_r != CYC_INTA1)
    else $error("vector taken outside the second acknowledge cycle");

  // Warm init restarts fetch only; caches and control bits stay
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      warm_d_r       <= 1'b0;
      o_pipe_flush_r <= 1'b0;
      o_fetch_addr_r <= RESET_VECTOR;
    end else begin
      warm_d_r       <= i_warm_init;
      o_pipe_flush_r <= i_warm_init && !warm_d_r;
      if (i_warm_init && !warm_d_r) begin
        o_fetch_addr_r <= RESET_VECTOR;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_cache_disable_bit_r   <= CD_RST;
      o_no_writethrough_bit_r <= NW_RST;
    end else if (i_ctl_write) begin
      o_cache_disable_bit_r   <= i_ctl_cd;
      o_no_writethrough_bit_r <= i_ctl_nw;
    end
  end

  AST_WARM_VECTOR: assert property (@(posedge i_clock) disable iff (i_reset)
    i_warm_init && !warm_d_r |=> o_pipe_flush_r && o_fetch_addr_r == RESET_VECTOR)
    else $error("warm init did not restart at the reset vector");

  AST_WARM_KEEPS: assert property (@(posedge i_clock) disable iff (i_reset)
    i_warm_init && !i_ctl_write |=> $stable(o_cache_disable_bit_r) &&
                                    $stable(o_no_writethrough_bit_r))
    else $error("warm init changed the cache control bits");

  // FPU fault: a new exception wins over a clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      fpu_pend_r             <= 1'b0;
      o_fpu_fault_output_n_r <= 1'b1;
      o_fpu_exc_ignored_r    <= 1'b0;
      o_fpu_exc_trap_r       <= 1'b0;
    end else begin
      o_fpu_exc_ignored_r <= i_fpu_check && fpu_pend_r && !i_fpu_fault_override_n;
      o_fpu_exc_trap_r    <= i_fpu_check && fpu_pend_r && i_fpu_fault_override_n;
      if (i_fpu_unmasked_exc) begin
        fpu_pend_r             <= 1'b1;
        o_fpu_fault_output_n_r <= 1'b0;
      end else if (i_fpu_clear) begin
        fpu_pend_r             <= 1'b0;
        o_fpu_fault_output_n_r <= 1'b1;
      end
    end
  end

  AST_FAULT_OUT: assert property (@(posedge i_clock) disable iff (i_reset)
    i_fpu_unmasked_exc |=> !o_fpu_fault_output_n_r && fpu_pend_r)
    else $error("fault output not asserted after exception");

  AST_IGNORE: assert property (@(posedge i_clock) disable iff (i_reset)
    o_fpu_exc_ignored_r |-> !o_fpu_exc_trap_r && !$past(i_fpu_fault_override_n))
    else $error("exception ignored without the override input");

  AST_STRAP: assert property (@(posedge i_clock) disable iff (i_reset)
    rst_d_r |=> o_test_float_r == !$past(i_flush_n))
    else $error("test float strap not taken at reset release");

endmodule

// File: logic/cbc_line_mem.sv
module cbc_line_mem
  import cbc_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // Write port
  input  wire logic              i_we,
  input  wire cbc_pkg::cbc_idx_t  i_waddr,
  input  wire cbc_pkg::cbc_line_t i_wdata,
  // Read port
  input  wire cbc_pkg::cbc_idx_t  i_raddr,
  output cbc_pkg::cbc_line_t      o_rdata
);

  cbc_line_t mem_r [LINES];

  // Hardware reset clears every line; a flush clears lines one by one through the write port; warm init never reaches here
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      for (int k = 0; k < LINES; k++) begin
        mem_r[k] <= LINE_RST;
      end
    end else if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rdata <= LINE_RST;
    end else begin
      o_rdata <= mem_r[i_raddr];
    end
  end

endmodule

// File: shared/cbc_pkg.sv
package cbc_pkg;

  localparam int          IDX_W        = 6;
  localparam int          LINES        = 64;
  localparam int          LINE_W       = 3;
  localparam int          VEC_W        = 8;
  localparam int          ADDR_W       = 32;
  localparam int          DATA_W       = 64;
  localparam int          LINE_IVALID  = 2;

  typedef logic [IDX_W-1:0]  cbc_idx_t;
  typedef logic [LINE_W-1:0] cbc_line_t;

  // Data cache state lives in the two low bits of a line entry
  localparam logic [1:0]  DST_INV      = 2'h0;
  localparam logic [1:0]  DST_SHARED   = 2'h1;
  localparam logic [1:0]  DST_EXCL     = 2'h2;
  localparam logic [1:0]  DST_MOD      = 2'h3;
  localparam cbc_line_t   LINE_RST     = 3'h0;
  localparam cbc_idx_t    LAST_IDX     = 6'h3f;

  localparam logic [ADDR_W-1:0] RESET_VECTOR = 32'hffff_fff0;
  localparam logic        CD_RST       = 1'h1;
  localparam logic        NW_RST       = 1'h1;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_FLOAT  = 4'h1,
    ST_HOLD   = 4'h2,
    ST_FL_RD  = 4'h3,
    ST_FL_CHK = 4'h4,
    ST_FL_WB  = 4'h5,
    ST_FL_ACK = 4'h6,
    ST_WB     = 4'h7,
    ST_INTA1  = 4'h8,
    ST_INTA2  = 4'h9
  } cbc_state_t;

  typedef enum logic [2:0] {
    CYC_NONE      = 3'h0,
    CYC_WRITEBACK = 3'h1,
    CYC_FLUSH_ACK = 3'h2,
    CYC_INTA1     = 3'h3,
    CYC_INTA2     = 3'h4
  } cbc_cycle_t;

  function automatic logic line_hit(input cbc_line_t l);
    line_hit = l[LINE_IVALID] | (l[1:0] != DST_INV);
  endfunction

  function automatic logic line_dirty(input cbc_line_t l);
    line_dirty = (l[1:0] == DST_MOD);
  endfunction

endpackage
